//--- rdmm_pkg.sv
`default_nettype none
package rdmm_pkg;
   // Clock and symbol timing.
   localparam int CLK_HZ         = 25_000_000;
   localparam int BASE_BAUD      = 600;
   localparam int OVS            = 8;
   localparam int BASE_DIV_DEF   = CLK_HZ / (BASE_BAUD * OVS);
   localparam int MAX_RATE_SHIFT = 5;
   localparam logic [2:0] PH_LAST   = 3'h7;
   localparam logic [2:0] PH_SAMPLE = 3'h4;
   localparam logic [2:0] BIT_LAST  = 3'h7;

   // Register addresses.
   localparam logic [7:0] ADDR_MODEM = 8'hdb;
   localparam logic [7:0] ADDR_BUF   = 8'hc9;
   localparam logic [7:0] ADDR_RCTL  = 8'hd9;
   localparam logic [7:0] ADDR_IRQF  = 8'h91;
   localparam logic [7:0] ADDR_IRQE  = 8'he8;
   localparam logic [7:0] ADDR_PREAMBLE_DETECT_CTRL  = 8'hd3;
   localparam logic [7:0] ADDR_SYNC  = 8'hd4;

   // Field positions.
   localparam int RATE_MSB  = 7;
   localparam int RATE_LSB  = 5;
   localparam int MODE_MSB  = 4;
   localparam int MODE_LSB  = 3;
   localparam int XOSC_MSB  = 2;
   localparam int BYTE_BIT  = 0;
   localparam int VIOL_BIT  = 1;
   localparam int IRQ_BIT   = 0;
   localparam int PEN_BIT   = 7;
   localparam int PREAMBLE_LENGTH_MSB  = 4;

   // Reset values.
   localparam logic [2:0] RATE_RST = 3'h3;
   localparam logic [1:0] MODE_RST = 2'h2;
   localparam logic [2:0] XOSC_RST = 3'h1;
   localparam logic [7:0] SYNC_RST = 8'h00;

   typedef enum logic [1:0] {
      MODE_NRZ   = 2'h0,
      MODE_MAN   = 2'h1,
      MODE_TRANS = 2'h2,
      MODE_UART  = 2'h3
   } rdmm_mode_t;

   typedef enum logic [2:0] {
      ST_HUNT = 3'h1,
      ST_SYNC = 3'h2,
      ST_RECV = 3'h4
   } rdmm_rx_state_t;
endpackage : rdmm_pkg
`default_nettype wire

//--- rdmm_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rdmm_tick_if;
   logic [2:0] rate;
   logic       tick;
   modport gen (input rate, output tick);
   modport sink (output rate, input tick);
endinterface : rdmm_tick_if
`default_nettype wire

//--- rdmm_baud.sv
`timescale 1ns/1ns
`default_nettype none
module rdmm_baud
   import rdmm_pkg::*;
#(
   parameter int BASE_DIV = BASE_DIV_DEF,
   parameter int DIV_W    = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Rate in, oversampling tick out.
   rdmm_tick_if.gen t
);
   logic [DIV_W-1:0] cnt;
   logic [DIV_W-1:0] div;
   logic [2:0]       sh;

   // The fastest rate must still leave a divider of at least two.
   if (BASE_DIV >= (2 ** DIV_W) || (BASE_DIV >> MAX_RATE_SHIFT) < 2) begin : g_chk
      $error("rdmm_baud: divider parameters out of range");
   end

   // Each rate code doubles the symbol rate; codes above the top rate are clamped.
   assign sh  = (t.rate > 3'(MAX_RATE_SHIFT)) ? 3'(MAX_RATE_SHIFT) : t.rate; // RULE20
   assign div = DIV_W'(BASE_DIV) >> sh;

   // Down counter that emits one tick per oversampling slot.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt    <= '0;
         t.tick <= 1'b0;
      end else if (cnt == '0) begin
         cnt    <= div - 1'b1; // RULE3
         t.tick <= 1'b1;
      end else begin
         cnt    <= cnt - 1'b1;
         t.tick <= 1'b0;
      end
   end

   tick_reload_a : assert property (@(posedge clk) disable iff (!arst_n) // RULE3
      (cnt == '0) |=> (t.tick && cnt == $past(div) - 1'b1))
      else $error("baud counter did not reload");
endmodule : rdmm_baud
`default_nettype wire

//--- rdmm_modem.sv
// Notes on behaviour
// RULE1: Two-bit field selects four line modes.
// RULE2: Software sets mode before enabling radio.
// RULE3: Sync modes run at selected symbol rate.
// RULE4: Receiver realigns bit clock on edges.
// RULE5: Manchester mode encodes and decodes itself.
// RULE6: Byte-wide bit picks bit or byte units.
// RULE7: Byte uses whole buffer, bit uses bit0.
// RULE8: Each unit needed or arrived sets flag.
// RULE9: Software polls flag or uses interrupt.
// RULE10: Optional preamble and delimiter detection on receive.
// RULE11: Reception starts after preamble then delimiter.
// RULE12: Preamble detection forces byte-wide operation.
// RULE13: Transparent uses buffer bit0; UART uses UART.
// RULE14: UART mode frees port pin from UART.
// RULE15: Bypass modes skip decisions, no byte-wide.
// RULE16: One is high-low, zero is low-high.
// RULE17: Manchester bit lasts two symbols.
// RULE18: Bad Manchester pair sets violation bit.
// RULE19: UART mode timing comes from UART.
// RULE20: Rate codes 0.6 to 4.8 kBaud, reset 011; here code 4 gives 9.6 kBaud and codes 5 and up give 19.2 kBaud.
// RULE21: Mode codes NRZ, Manchester, transparent, UART; reset transparent.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module rdmm_modem
   import rdmm_pkg::*;
#(
   parameter int BASE_DIV = BASE_DIV_DEF,
   parameter int DIV_W    = 16
) (
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   // Register port.
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // Transceiver state.
   input  wire logic       RADIO_ON,
   input  wire logic       TX_MODE,
   // FSK modem side.
   input  wire logic       RX_DATA_IN,
   output logic            TX_DATA,
   // First UART and its port pin.
   input  wire logic       UART_TXD,
   output logic            UART_RXD,
   output logic            PORT3_LINE1_UART_DRIVE,
   // Radio interrupt request.
   output logic            IRQ_REQ
);
   // Register state.
   logic [2:0]     rate;
   rdmm_mode_t     mode;
   logic [2:0]     xosc_sel;
   logic [7:0]     rbuf;
   logic           byte_mode;
   logic           man_viol;
   logic           irq_flag;
   logic           irq_en;
   logic           pre_on;
   logic [4:0]     pre_len;
   logic [7:0]     sync_delim;
   // Receive input synchroniser and resync.
   logic           rx_meta;
   logic           rx_s;
   logic           rx_prev;
   logic [2:0]     rx_ph;
   logic           rx_half;
   logic           rx_first;
   // Receive framing.
   rdmm_rx_state_t st;
   logic [4:0]     pre_cnt;
   logic           last_bit;
   logic [7:0]     win;
   logic [7:0]     rx_shift;
   logic [2:0]     rx_cnt;
   // Transmit path.
   logic [2:0]     tx_ph;
   logic           tx_half;
   logic           tx_bit;
   logic [7:0]     tx_shift;
   logic [2:0]     tx_cnt;
   // Decoded helpers.
   logic sync_mode, eff_byte, tx_run, rx_run, trans_rx;
   logic tx_sym, tx_bnd, tx_load, next_bit;
   logic rx_sym, rx_bit_v, rx_bit, rx_bad, rx_del;
   logic [7:0] rx_word;
   logic wr_modem, wr_buf, wr_rctl, wr_irqf, wr_irqe, wr_preamble_detect_ctrl, wr_sync;

   rdmm_tick_if tk ();

   assign tk.rate = rate; // RULE3

   rdmm_baud #(
      .BASE_DIV (BASE_DIV),
      .DIV_W    (DIV_W)
   ) u_baud (
      .clk    (CLK),
      .arst_n (ARST_N),
      .t      (tk)
   );

   // Write strobes per register.
   assign wr_modem = WR && (ADDR == ADDR_MODEM);
   assign wr_buf   = WR && (ADDR == ADDR_BUF);
   assign wr_rctl  = WR && (ADDR == ADDR_RCTL);
   assign wr_irqf  = WR && (ADDR == ADDR_IRQF);
   assign wr_irqe  = WR && (ADDR == ADDR_IRQE);
   assign wr_preamble_detect_ctrl  = WR && (ADDR == ADDR_PREAMBLE_DETECT_CTRL);
   assign wr_sync  = WR && (ADDR == ADDR_SYNC);

   // Mode decode; only the two synchronous modes use the data decision logic.
   assign sync_mode = (mode == MODE_NRZ) || (mode == MODE_MAN); // RULE1 RULE15
   assign eff_byte  = sync_mode && (byte_mode || pre_on); // RULE6 RULE12
   assign tx_run    = RADIO_ON && TX_MODE && sync_mode;
   assign rx_run    = RADIO_ON && !TX_MODE && sync_mode;
   assign trans_rx  = RADIO_ON && !TX_MODE && (mode == MODE_TRANS);

   // Control registers written by software.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rate       <= RATE_RST; // RULE20
         mode       <= rdmm_mode_t'(MODE_RST); // RULE21
         xosc_sel   <= XOSC_RST;
         byte_mode  <= 1'b0;
         irq_en     <= 1'b0;
         pre_on     <= 1'b0;
         pre_len    <= 5'h00;
         sync_delim <= SYNC_RST;
      end else begin
         if (wr_modem) begin
            rate     <= WDATA[RATE_MSB:RATE_LSB];
            mode     <= rdmm_mode_t'(WDATA[MODE_MSB:MODE_LSB]); // RULE1
            xosc_sel <= WDATA[XOSC_MSB:0];
         end
         if (wr_rctl) begin
            byte_mode <= WDATA[BYTE_BIT];
         end
         if (wr_irqe) begin
            irq_en <= WDATA[IRQ_BIT];
         end
         if (wr_preamble_detect_ctrl) begin
            pre_on  <= WDATA[PEN_BIT]; // RULE10
            pre_len <= WDATA[PREAMBLE_LENGTH_MSB:0];
         end
         if (wr_sync) begin
            sync_delim <= WDATA;
         end
      end
   end

   // Read port; data stand for the one cycle after the strobe, unmapped reads give zero.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RDATA <= 8'h00;
      end else if (!RD) begin
         RDATA <= 8'h00;
      end else if (ADDR == ADDR_MODEM) begin
         RDATA <= {rate, mode, xosc_sel};
      end else if (ADDR == ADDR_BUF) begin
         RDATA <= rbuf;
      end else if (ADDR == ADDR_RCTL) begin
         RDATA <= {6'h00, man_viol, byte_mode};
      end else if (ADDR == ADDR_IRQF) begin
         RDATA <= {7'h00, irq_flag};
      end else if (ADDR == ADDR_IRQE) begin
         RDATA <= {7'h00, irq_en};
      end else if (ADDR == ADDR_PREAMBLE_DETECT_CTRL) begin
         RDATA <= {pre_on, 2'h0, pre_len};
      end else if (ADDR == ADDR_SYNC) begin
         RDATA <= sync_delim;
      end else begin
         RDATA <= 8'h00;
      end
   end

   // Two flops bring the demodulator bit into the clock domain; a third gives edges.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_meta <= 1'b0;
         rx_s    <= 1'b0;
         rx_prev <= 1'b0;
      end else begin
         rx_meta <= RX_DATA_IN;
         rx_s    <= rx_meta;
         rx_prev <= rx_s;
      end
   end

   // Receive phase restarts on every line edge, so sampling tracks the sender.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_ph <= 3'h0;
      end else if (!rx_run || (rx_s != rx_prev)) begin
         rx_ph <= 3'h0; // RULE4
      end else if (tk.tick) begin
         rx_ph <= rx_ph + 3'h1;
      end
   end

   assign rx_sym   = rx_run && tk.tick && (rx_ph == PH_SAMPLE) && (rx_s == rx_prev); // RULE4
   // A Manchester bit is the first half of a pair whose halves differ.
   assign rx_bit_v = rx_sym && ((mode == MODE_NRZ) || (rx_half && (rx_first != rx_s))); // RULE5 RULE17
   assign rx_bit   = (mode == MODE_NRZ) ? rx_s : rx_first; // RULE5 RULE16
   assign rx_bad   = rx_sym && (mode == MODE_MAN) && rx_half && (rx_first == rx_s); // RULE18

   // Pair tracking; after a bad pair the last symbol opens a new pair to slip alignment.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_half  <= 1'b0;
         rx_first <= 1'b0;
      end else if (!rx_run) begin
         rx_half <= 1'b0;
      end else if (rx_sym && (mode == MODE_MAN)) begin
         if (!rx_half || rx_bad) begin
            rx_first <= rx_s;
            rx_half  <= 1'b1;
         end else begin
            rx_half <= 1'b0;
         end
      end
   end

   // Violation status; a new violation wins over a software clear in the same cycle.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         man_viol <= 1'b0;
      end else if (rx_bad) begin
         man_viol <= 1'b1; // RULE18
      end else if (wr_rctl && !WDATA[VIOL_BIT]) begin
         man_viol <= 1'b0;
      end
   end

   // Framing: hunt for alternating preamble, then the delimiter, then deliver data.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st       <= ST_RECV;
         pre_cnt  <= 5'h00;
         last_bit <= 1'b0;
         win      <= 8'h00;
         rx_shift <= 8'h00;
         rx_cnt   <= 3'h0;
      end else if (!rx_run) begin
         st      <= pre_on ? ST_HUNT : ST_RECV; // RULE10
         pre_cnt <= 5'h00;
         rx_cnt  <= 3'h0;
      end else if (rx_bit_v) begin
         last_bit <= rx_bit;
         win      <= {win[6:0], rx_bit};
         case (st)
            ST_HUNT: begin
               if (rx_bit == last_bit) begin
                  pre_cnt <= 5'h00;
               end else if (pre_cnt >= pre_len) begin
                  st <= ST_SYNC; // RULE11
               end else begin
                  pre_cnt <= pre_cnt + 5'h01;
               end
            end
            ST_SYNC: begin
               if ({win[6:0], rx_bit} == sync_delim) begin
                  st     <= ST_RECV; // RULE11
                  rx_cnt <= 3'h0;
               end
            end
            ST_RECV: begin
               rx_shift <= {rx_shift[6:0], rx_bit};
               rx_cnt   <= rx_cnt + 3'h1;
            end
            default: begin
               st <= ST_HUNT;
            end
         endcase
      end
   end

   assign rx_del  = rx_bit_v && (st == ST_RECV) && (!eff_byte || (rx_cnt == BIT_LAST)); // RULE6
   assign rx_word = eff_byte ? {rx_shift[6:0], rx_bit} : {rbuf[7:1], rx_bit}; // RULE7

   // Data buffer; hardware delivery wins over a software write in the same cycle.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rbuf <= 8'h00;
      end else begin
         if (wr_buf) begin
            rbuf <= WDATA;
         end
         if (trans_rx) begin
            rbuf[0] <= rx_s; // RULE13
         end
         if (rx_del) begin
            rbuf <= rx_word; // RULE7
         end
      end
   end

   // Transmit symbol timing from the shared oversampling tick.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tx_ph <= 3'h0;
      end else if (!tx_run) begin
         tx_ph <= 3'h0;
      end else if (tk.tick) begin
         tx_ph <= tx_ph + 3'h1; // RULE3
      end
   end

   assign tx_sym   = tx_run && tk.tick && (tx_ph == PH_LAST);
   assign tx_bnd   = tx_sym && !tx_half; // RULE17
   assign tx_load  = tx_bnd && (!eff_byte || (tx_cnt == 3'h0)); // RULE6
   assign next_bit = !eff_byte ? rbuf[0] : ((tx_cnt == 3'h0) ? rbuf[7] : tx_shift[6]); // RULE7

   // Bit sequencing; the buffer is copied at each unit start so software may refill early.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tx_half  <= 1'b0;
         tx_bit   <= 1'b0;
         tx_shift <= 8'h00;
         tx_cnt   <= 3'h0;
      end else if (!tx_run) begin
         tx_half <= 1'b0;
         tx_cnt  <= 3'h0;
      end else if (tx_bnd) begin
         tx_bit  <= next_bit;
         tx_half <= (mode == MODE_MAN); // RULE17
         if (eff_byte && (tx_cnt == 3'h0)) begin
            tx_shift <= rbuf;
            tx_cnt   <= BIT_LAST;
         end else if (eff_byte) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            tx_cnt   <= tx_cnt - 3'h1;
         end
      end else if (tx_sym) begin
         tx_half <= 1'b0;
      end
   end

   // Modulator bit; one means the high frequency.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TX_DATA <= 1'b0;
      end else if (tx_run) begin
         if (tx_bnd) begin
            TX_DATA <= next_bit; // RULE16
         end else if (tx_sym) begin
            TX_DATA <= !tx_bit; // RULE5 RULE16
         end
      end else if (RADIO_ON && TX_MODE && (mode == MODE_TRANS)) begin
         TX_DATA <= rbuf[0]; // RULE13 RULE15
      end else if (RADIO_ON && TX_MODE && (mode == MODE_UART)) begin
         TX_DATA <= UART_TXD; // RULE13 RULE19
      end else begin
         TX_DATA <= 1'b0;
      end
   end

   // UART receive feed and port pin release; the UART does its own timing.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         UART_RXD               <= 1'b1;
         PORT3_LINE1_UART_DRIVE <= 1'b1;
      end else begin
         UART_RXD               <= (mode == MODE_UART) ? rx_s : 1'b1; // RULE19
         PORT3_LINE1_UART_DRIVE <= (mode != MODE_UART); // RULE14
      end
   end

   // Radio flag; a unit event wins over a software clear in the same cycle.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_flag <= 1'b0;
         IRQ_REQ  <= 1'b0;
      end else begin
         if (tx_load || rx_del) begin
            irq_flag <= 1'b1; // RULE8
         end else if (wr_irqf && !WDATA[IRQ_BIT]) begin
            irq_flag <= 1'b0;
         end
         IRQ_REQ <= irq_flag && irq_en;
      end
   end

   irq_set_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE8
      (tx_load || rx_del) |=> irq_flag ##1 (IRQ_REQ == $past(irq_en)))
      else $error("unit event did not raise the radio flag");
   rst_value_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE20 RULE21
      $rose(ARST_N) |-> (rate == 3'h3 && mode == MODE_TRANS))
      else $error("mode register reset value wrong");
   force_byte_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE12
      (pre_on && rx_run && rx_bit_v && st == ST_RECV && rx_cnt != BIT_LAST) |-> !rx_del)
      else $error("bit delivered while preamble detection forces byte mode");
   bit_buf_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE7
      (rx_del && !eff_byte) |=> (rbuf[0] == $past(rx_bit) && rbuf[7:1] == $past(rbuf[7:1])))
      else $error("bit mode delivery touched more than bit 0");
   man_first_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
      (tx_bnd && mode == MODE_MAN) |=> (TX_DATA == tx_bit && tx_half))
      else $error("Manchester first half wrong");
   man_second_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE5
      (tx_sym && tx_half) |=> (TX_DATA == !$past(tx_bit) && !tx_half))
      else $error("Manchester second half not inverted");
   viol_set_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE18
      rx_bad |=> man_viol)
      else $error("Manchester violation not flagged");
   uart_path_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE13
      (RADIO_ON && TX_MODE && mode == MODE_UART) |=> (TX_DATA == $past(UART_TXD)))
      else $error("UART bit not passed to modulator");
   port_free_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE14
      (mode == MODE_UART) [*2] |-> !PORT3_LINE1_UART_DRIVE)
      else $error("port pin still driven by UART");
   trans_tx_a : assert property (@(posedge CLK) disable iff (!ARST_N) // RULE15
      (RADIO_ON && TX_MODE && mode == MODE_TRANS) |=> (TX_DATA == $past(rbuf[0]) && !tx_load))
      else $error("transparent transmit not from buffer bit 0");
endmodule : rdmm_modem
`default_nettype wire

//--- rdmm_fsk_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the FSK modulator and demodulator: it plays symbols onto the receive line.
module rdmm_fsk_model (
   // Clock.
   input  wire logic clk,
   // Modulator bit in, demodulator bit out.
   input  wire logic tx_data,
   output logic      rx_data
);
   // The demodulator always drives its output, so the line keeps the last symbol.
   initial rx_data = 1'b0;

   // Plays n symbols MSB first, each held for per clocks; a one stands for the high frequency.
   task automatic play(input logic [31:0] sym, input int n, input int per);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk);
         rx_data <= sym[i];
         repeat (per - 1) @(posedge clk);
      end
   endtask : play
endmodule : rdmm_fsk_model
`default_nettype wire

//--- tb_radio_data_mode_modem.sv
`timescale 1ns/1ns
`default_nettype none
module tb_radio_data_mode_modem
   import rdmm_pkg::*;
;
   // Rate code 3 with a divider of 64 gives 8 clocks a tick, 64 clocks a symbol.
   localparam int SYM = 64;
   typedef struct packed {logic [7:0] w; logic p3; logic urx;} rdmm_row_t;
   logic       clk, arst_n, wr, rd, radio_on, tx_mode, uart_txd;
   logic [7:0] addr, wdata, rdata, rv;
   logic       tx_data, uart_rxd, p3_drive, irq_req, rx_line;
   int         errors = 0;
   int         cmp_count = 0;
   // Mode writes beside the port pin drive and the UART receive bit, receive line low.
   rdmm_row_t  rows [4] = '{'{8'h60, 1'b1, 1'b1}, '{8'h68, 1'b1, 1'b1},
                            '{8'h70, 1'b1, 1'b1}, '{8'h78, 1'b0, 1'b0}};

   rdmm_modem #(.BASE_DIV(64), .DIV_W(16)) i_rdmm_modem (
      .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .RADIO_ON(radio_on), .TX_MODE(tx_mode), .RX_DATA_IN(rx_line), .TX_DATA(tx_data),
      .UART_TXD(uart_txd), .UART_RXD(uart_rxd), .PORT3_LINE1_UART_DRIVE(p3_drive), .IRQ_REQ(irq_req));
   rdmm_fsk_model i_rdmm_fsk_model (.clk(clk), .tx_data(tx_data), .rx_data(rx_line));

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // One-cycle register write.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // One-cycle register read; data standing in the cycle after the strobe are taken at the edge ending it.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask : rd_reg

   // Polls the interrupt request under a bound, since software may poll instead of vectoring.
   task automatic wait_irq();
      for (int i = 0; i < 4 * SYM; i++) begin
         @(negedge clk);
         if (irq_req === 1'b1) return;
      end
      chk({7'h0, irq_req}, 8'h01, "radio flag never set");
      close_out();
   endtask : wait_irq

   // Sends eight bits and samples every symbol at its middle, MSB first.
   task automatic tx_run(input logic [7:0] mv, input logic [7:0] ctl, input logic man,
                         input logic [7:0] d, input logic [7:0] e);
      wr_reg(ADDR_MODEM, mv);
      wr_reg(ADDR_RCTL, ctl);
      wr_reg(ADDR_BUF, d);
      wr_reg(ADDR_IRQF, 8'h00);
      @(posedge clk);
      radio_on <= 1'b1;
      tx_mode  <= 1'b1;
      wait_irq();
      repeat (SYM / 2) @(negedge clk);
      for (int i = 7; i >= 0; i--) begin
         chk({7'h0, tx_data}, {7'h0, e[i]}, "transmit bit");
         repeat (SYM) @(negedge clk);
         if (man) begin
            chk({7'h0, tx_data}, {7'h0, ~e[i]}, "second half");
            repeat (SYM) @(negedge clk);
         end
      end
      @(posedge clk);
      radio_on <= 1'b0;
   endtask : tx_run

   // Watchdog: a hang counts as a mismatch and ends the run.
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      close_out();
   end

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      {wr, rd, radio_on, tx_mode, uart_txd} = 5'h00;
      addr  = 8'h00;
      wdata = 8'h00;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rd_reg(ADDR_MODEM, rv);
      chk(rv, 8'h71, "modem reset value");
      rd_reg(8'h00, rv);
      chk(rv, 8'h00, "unmapped read");
      chk({6'h0, p3_drive, uart_rxd}, 8'h03, "pins after reset");
      foreach (rows[i]) begin
         wr_reg(ADDR_MODEM, rows[i].w);
         rd_reg(ADDR_MODEM, rv);
         chk(rv, rows[i].w, "mode readback");
         repeat (4) @(posedge clk);
         chk({6'h0, p3_drive, uart_rxd}, {6'h0, rows[i].p3, rows[i].urx}, "mode pins");
      end
      wr_reg(ADDR_IRQE, 8'h01);
      tx_run(8'h60, 8'h01, 1'b0, 8'ha5, 8'ha5);
      tx_run(8'h68, 8'h01, 1'b1, 8'h3c, 8'h3c);
      tx_run(8'h60, 8'h00, 1'b0, 8'ha5, 8'hff);
      // Preamble, delimiter, then one data byte with byte mode left off.
      wr_reg(ADDR_MODEM, 8'h60);
      wr_reg(ADDR_RCTL, 8'h00);
      wr_reg(ADDR_PREAMBLE_DETECT_CTRL, 8'h83);
      wr_reg(ADDR_SYNC, 8'hd3);
      wr_reg(ADDR_IRQF, 8'h00);
      @(posedge clk);
      tx_mode  <= 1'b0;
      radio_on <= 1'b1;
      i_rdmm_fsk_model.play(32'haaaad35c, 32, SYM);
      wait_irq();
      rd_reg(ADDR_BUF, rv);
      chk(rv, 8'h5c, "framed byte");
      // Manchester receive: a clean stream leaves the violation bit clear, a run of ones sets it.
      radio_on <= 1'b0;
      wr_reg(ADDR_PREAMBLE_DETECT_CTRL, 8'h00);
      wr_reg(ADDR_MODEM, 8'h68);
      @(posedge clk);
      radio_on <= 1'b1;
      fork
         i_rdmm_fsk_model.play(32'haaaaaaaa, 32, SYM);
         begin
            repeat (12 * SYM) @(posedge clk);
            wr_reg(ADDR_RCTL, 8'h00);
            repeat (12 * SYM) @(posedge clk);
            rd_reg(ADDR_RCTL, rv);
            chk(rv & 8'h02, 8'h00, "clean stream");
         end
      join
      i_rdmm_fsk_model.play(32'h0000000f, 4, SYM);
      rd_reg(ADDR_RCTL, rv);
      chk(rv & 8'h02, 8'h02, "violation bit");
      // Transparent receive lands on buffer bit 0 only, even with byte mode set.
      radio_on <= 1'b0;
      wr_reg(ADDR_MODEM, 8'h70);
      wr_reg(ADDR_RCTL, 8'h01);
      wr_reg(ADDR_BUF, 8'h00);
      @(posedge clk);
      radio_on <= 1'b1;
      i_rdmm_fsk_model.play(32'h00000001, 1, 8);
      repeat (4) @(posedge clk);
      rd_reg(ADDR_BUF, rv);
      chk(rv, 8'h01, "transparent bit");
      // Bypass transmit: transparent sends buffer bit 0, UART mode passes the UART bit straight on.
      radio_on <= 1'b0;
      tx_mode  <= 1'b1;
      wr_reg(ADDR_BUF, 8'h01);
      @(posedge clk);
      radio_on <= 1'b1;
      repeat (3) @(posedge clk);
      chk({7'h0, tx_data}, 8'h01, "transparent transmit bit");
      radio_on <= 1'b0;
      uart_txd <= 1'b1;
      wr_reg(ADDR_MODEM, 8'h78);
      @(posedge clk);
      radio_on <= 1'b1;
      repeat (3) @(posedge clk);
      chk({7'h0, tx_data}, 8'h01, "UART transmit high");
      chk({7'h0, uart_rxd}, {7'h0, rx_line}, "UART receive bit");
      uart_txd <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h0, tx_data}, 8'h00, "UART transmit low");
      close_out();
   end
endmodule : tb_radio_data_mode_modem
`default_nettype wire
